// ==== rtl/omc_pkg.sv ====
package omc_pkg;
   // op_mode_field codes (bits 3:2 of osc_control_reg)
   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_HALT = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   // register offsets on the plain port
   localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_CTRL = 4'h2;
   // osc_control_reg field positions
   localparam int SEL_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int MODE_LSB = 2;
   // status register field positions
   localparam int PD_BIT = 3;
   localparam int TO_BIT = 4;
   // ctrl register field positions
   localparam int WDT_EN_BIT = 0;
   localparam int T0_EN_BIT = 1;
   localparam int T1_EN_BIT = 2;
   localparam int LCK_T0_BIT = 3;
   // reset values
   localparam logic PD_RESET = 1'b1;
   localparam logic TO_RESET = 1'b1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // halt wake-up stable time in system clocks
   localparam int WAKE_CYCLES = 16;
   localparam logic [4:0] WAKE_LOAD = 5'(WAKE_CYCLES);
   // interrupt vector
   localparam logic [10:0] INT_VECTOR = 11'h008;

   typedef enum {ST_RUN, ST_STANDBY, ST_HALT, ST_WAKE} omc_state_t;

   // wake sources
   typedef struct packed {
      logic t0_ovf;
      logic t1_udf;
      logic wdt;
      logic pb_chg;
      logic ext;
      logic lvd;
      logic tp_cmp;
      logic tp_ovf;
   } omc_wake_t;

   typedef struct packed {
      omc_state_t st;
      logic sel_fast;
      logic stop_fast;
      logic [7:0] ctrl;
      logic pd;
      logic to;
      logic [4:0] wake_cnt;
      logic gie_at_entry;
      logic [7:0] rdata;
      logic fast_en;
      logic slow_en;
      logic sys_fast;
      logic exec_en;
      logic periph_en;
      logic t0_run;
      logic t1_run;
      logic wdt_run;
      logic wdt_clr;
      logic t0_slow_clk;
      logic vec_req;
      logic inst_div4;
   } omc_state_s_t;
endpackage

// ==== rtl/omc_top.sv ====
// Decided for this implementation: the register addresses and strobed register access.
module omc_top (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic startup_fast,
   input wire logic inst_div4_cfg,
   input wire logic wdt_option,
   input wire logic t0_src_cfg,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic sleep_exec,
   input wire logic global_int_enable,
   input wire omc_pkg::omc_wake_t wake_in,
   output logic [7:0] reg_rdata,
   output logic fast_osc_en,
   output logic slow_osc_en,
   output logic sys_clk_fast,
   output logic exec_en,
   output logic periph_en,
   output logic timer0_run,
   output logic timer1_run,
   output logic watchdog_run,
   output logic watchdog_clear,
   output logic timer0_slow_clk,
   output logic vector_req,
   output logic [10:0] vector_addr,
   output logic inst_div4,
   output logic power_down_flag,
   output logic timeout_flag
);
   // state map of the controller
   //   run: executing, clock per select bit (normal or slow)
   //   standby: execution parked, slow oscillator kept alive
   //   halt: both oscillators off, only the watchdog may tick
   //   wake: oscillators back on, counting the stable time
   // run covers both normal and slow mode; the select bit alone
   // tells them apart, so a wake simply lands in run again
   //
   // entry paths
   //   write of mode code 01, or a sleep pulse: halt
   //   write of mode code 10: standby
   //   any other code: stays running, field reads back as run
   // halt entry wins over standby if both arrive together,
   // since halt is the deeper state and also clears the watchdog
   //
   // exit paths
   //   standby: any synced wake source, straight back to run
   //   halt: only the five outside sources, via the wake wait
   //   wake: no exit until the counter runs out; wake events
   //   seen here are dropped since the core is resuming anyway
   //
   // limitations a user must know
   //   wake sources are levels; a pulse shorter than one clock
   //   may be lost in the synchroniser
   //   a wake level that stands at entry ends the park at once
   //   the stop bit is honoured as written, even in the same
   //   write that sets the select bit; keeping the two apart is
   //   left to software, as a hang is the only outcome otherwise
   //
   // every output but the constant vector_addr comes from the state register, so downstream
   // clock gating sees clean edges with no decode glitches

   // mode field of a write; both entry decodes share it
   function automatic logic [1:0] wr_mode(input logic [7:0] d);
      wr_mode = d[omc_pkg::MODE_LSB +: 2];
   endfunction

   omc_pkg::omc_state_s_t s_q;
   omc_pkg::omc_state_s_t s_d;
   omc_pkg::omc_wake_t wake_s1_q;
   omc_pkg::omc_wake_t wake_s2_q;
   logic rst_seen_q;

   // wake sources come from other logic and pins: two-stage sync
   // costs two cycles of wake latency, but keeps metastable
   // levels away from the state decode below
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wake_s1_q <= '0;
         wake_s2_q <= '0;
      end
      else
      begin
         wake_s1_q <= wake_in;
         wake_s2_q <= wake_s1_q;
      end
   end

   logic wr_osc;
   logic wr_ctrl;
   logic halt_req;
   logic stby_req;
   logic standby_wake;
   logic halt_wake;
   logic [1:0] mode_rd;
   logic [7:0] osc_rd;

   assign wr_osc = reg_wr && (reg_addr == omc_pkg::OFS_OSC_CTRL);
   assign wr_ctrl = reg_wr && (reg_addr == omc_pkg::OFS_CTRL);
   assign halt_req = sleep_exec
      || (wr_osc && wr_mode(reg_wdata) == omc_pkg::MODE_HALT);
   assign stby_req = wr_osc
      && wr_mode(reg_wdata) == omc_pkg::MODE_STANDBY;
   // any of the eight standby sources
   assign standby_wake = |wake_s2_q;
   // timers and lvd cannot wake halt since they are stopped there
   assign halt_wake = wake_s2_q.wdt || wake_s2_q.pb_chg || wake_s2_q.ext
      || wake_s2_q.tp_cmp || wake_s2_q.tp_ovf;
   // mode field reads run code unless parked
   always_comb
   begin
      unique case (s_q.st)
         omc_pkg::ST_STANDBY: mode_rd = omc_pkg::MODE_STANDBY;
         omc_pkg::ST_HALT, omc_pkg::ST_WAKE: mode_rd = omc_pkg::MODE_HALT;
         omc_pkg::ST_RUN: mode_rd = omc_pkg::MODE_RUN;
      endcase
   end
   always_comb
   begin
      osc_rd = 8'h00;
      osc_rd[omc_pkg::SEL_BIT] = s_q.sel_fast;
      osc_rd[omc_pkg::STOP_BIT] = s_q.stop_fast;
      osc_rd[omc_pkg::MODE_LSB +: 2] = mode_rd;
   end

   // next-state of the whole controller
   // one copy of the state is built here and registered below;
   // strobes (watchdog clear, vector) default low so they last
   // exactly one cycle, and read data clears when not read
   // bus writes act in any state, so software may still change
   // the select or stop bit around a park request
   // derived outputs are taken from the next state rather than
   // the current one, which keeps them in step with the state
   always_comb
   begin
      s_d = s_q;
      s_d.wdt_clr = 1'b0;
      s_d.vec_req = 1'b0;
      s_d.rdata = 8'h00;
      // strap caught on the first clock after reset release
      if (!rst_seen_q)
      begin
         s_d.sel_fast = startup_fast;
      end
      if (wr_osc)
      begin
         s_d.sel_fast = reg_wdata[omc_pkg::SEL_BIT];
         s_d.stop_fast = reg_wdata[omc_pkg::STOP_BIT];
      end
      if (wr_ctrl)
      begin
         s_d.ctrl = reg_wdata;
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            omc_pkg::OFS_OSC_CTRL: s_d.rdata = osc_rd;
            omc_pkg::OFS_STATUS: s_d.rdata = {3'h0, s_q.to, s_q.pd, 3'h0};
            omc_pkg::OFS_CTRL: s_d.rdata = s_q.ctrl;
            default: s_d.rdata = 8'h00;
         endcase
      end
      unique case (s_q.st)
         omc_pkg::ST_RUN:
         begin
            if (halt_req)
            begin
               s_d.st = omc_pkg::ST_HALT;
               s_d.pd = 1'b0;
               s_d.to = 1'b1;
               s_d.wdt_clr = 1'b1;
               s_d.gie_at_entry = global_int_enable;
            end
            else if (stby_req)
            begin
               s_d.st = omc_pkg::ST_STANDBY;
               s_d.gie_at_entry = global_int_enable;
            end
         end
         omc_pkg::ST_STANDBY:
         begin
            // no stable time: an oscillator kept running
            if (standby_wake)
            begin
               s_d.st = omc_pkg::ST_RUN;
               s_d.vec_req = s_q.gie_at_entry;
            end
         end
         omc_pkg::ST_HALT:
         begin
            if (halt_wake)
            begin
               s_d.st = omc_pkg::ST_WAKE;
               s_d.wake_cnt = omc_pkg::WAKE_LOAD;
            end
         end
         omc_pkg::ST_WAKE:
         begin
            s_d.wake_cnt = s_q.wake_cnt - 5'h01;
            if (s_q.wake_cnt == 5'h01)
            begin
               s_d.st = omc_pkg::ST_RUN;
               s_d.vec_req = s_q.gie_at_entry;
            end
         end
      endcase
      // derived outputs from the next state, registered
      s_d.exec_en = (s_d.st == omc_pkg::ST_RUN);
      s_d.slow_en = (s_d.st != omc_pkg::ST_HALT);
      // oscillators restart during the wake wait so clocks are stable
      s_d.fast_en = !s_d.stop_fast && (s_d.st != omc_pkg::ST_HALT);
      s_d.sys_fast = s_d.sel_fast;
      s_d.periph_en = (s_d.st == omc_pkg::ST_RUN);
      s_d.t0_run = s_d.ctrl[omc_pkg::T0_EN_BIT]
         && (s_d.st == omc_pkg::ST_RUN || s_d.st == omc_pkg::ST_STANDBY);
      s_d.t1_run = s_d.ctrl[omc_pkg::T1_EN_BIT]
         && (s_d.st == omc_pkg::ST_RUN || s_d.st == omc_pkg::ST_STANDBY);
      s_d.wdt_run = wdt_option && s_d.ctrl[omc_pkg::WDT_EN_BIT];
      s_d.t0_slow_clk = s_d.ctrl[omc_pkg::LCK_T0_BIT] && t0_src_cfg
         && s_d.sel_fast && (s_d.st == omc_pkg::ST_RUN);
      s_d.inst_div4 = inst_div4_cfg;
   end

   // single state register
   // reset leaves the block running with both oscillators on;
   // the strap is then caught one clock after release
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.st <= omc_pkg::ST_RUN;
         s_q.pd <= omc_pkg::PD_RESET;
         s_q.to <= omc_pkg::TO_RESET;
         s_q.ctrl <= omc_pkg::CTRL_RESET;
         s_q.slow_en <= 1'b1;
         s_q.fast_en <= 1'b1;
         s_q.exec_en <= 1'b1;
         s_q.periph_en <= 1'b1;
         rst_seen_q <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
         rst_seen_q <= 1'b1;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign fast_osc_en = s_q.fast_en;
   assign slow_osc_en = s_q.slow_en;
   assign sys_clk_fast = s_q.sys_fast;
   assign exec_en = s_q.exec_en;
   assign periph_en = s_q.periph_en;
   assign timer0_run = s_q.t0_run;
   assign timer1_run = s_q.t1_run;
   assign watchdog_run = s_q.wdt_run;
   assign watchdog_clear = s_q.wdt_clr;
   assign timer0_slow_clk = s_q.t0_slow_clk;
   assign vector_req = s_q.vec_req;
   assign vector_addr = omc_pkg::INT_VECTOR;
   assign inst_div4 = s_q.inst_div4;
   assign power_down_flag = s_q.pd;
   assign timeout_flag = s_q.to;
endmodule

// ==== dv/omc_wake_src.sv ====
module omc_wake_src (
   input wire logic clock,
   input wire logic [7:0] fire,
   output omc_pkg::omc_wake_t wake_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] hold_q = 2'h0;
   initial wake_in = '0;
   // event sources hold a level a few cycles so the two-flop sync sees it
   always @(posedge clock)
   begin
      if (fire != 8'h00)
      begin
         wake_in <= fire;
         hold_q <= 2'h2;
      end
      else if (hold_q != 2'h0)
         hold_q <= hold_q - 2'h1;
      else
         wake_in <= '0;
   end
endmodule

// ==== dv/omc_top_chk.sv ====
module omc_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic sleep_exec,
   input wire logic fast_osc_en,
   input wire logic slow_osc_en,
   input wire logic sys_clk_fast,
   input wire logic exec_en,
   input wire logic timer0_run,
   input wire logic timer1_run,
   input wire logic watchdog_clear,
   input wire logic timer0_slow_clk,
   input wire logic vector_req,
   input wire logic power_down_flag,
   input wire logic timeout_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // only writes taken while running count as mode requests
   wire wr0 = reg_wr && reg_addr == omc_pkg::OFS_OSC_CTRL && exec_en;
   sequence halted_s; !exec_en && !fast_osc_en && !slow_osc_en; endsequence
   sequence wake_s; (!exec_en)[*8] ##1 (!exec_en)[*8] ##1 exec_en; endsequence
   halt_write_a: assert property (wr0 && reg_wdata[3:2] == omc_pkg::MODE_HALT |=>
      halted_s and (!power_down_flag && timeout_flag && watchdog_clear)) else $error("halt entry");
   sleep_halt_a: assert property (sleep_exec && exec_en |=> halted_s ##0 watchdog_clear)
      else $error("sleep entry");
   standby_entry_a: assert property (wr0 && reg_wdata[3:2] == omc_pkg::MODE_STANDBY |=>
      !exec_en && slow_osc_en && !watchdog_clear) else $error("standby entry");
   halt_timers_a: assert property (!slow_osc_en |-> !timer0_run && !timer1_run)
      else $error("timer in halt");
   wake_wait_a: assert property ($rose(slow_osc_en) |-> wake_s) else $error("wake time");
   vector_pulse_a: assert property (vector_req |-> $rose(exec_en) ##1 !vector_req)
      else $error("vector pulse");
   sel_write_a: assert property (wr0 |=> sys_clk_fast == $past(reg_wdata[0]))
      else $error("clock select");
   stop_write_a: assert property (wr0 && reg_wdata[1] |=> !fast_osc_en)
      else $error("fast stop");
   run_keep_a: assert property (wr0 && reg_wdata[3:1] == 3'h0 |=>
      fast_osc_en && slow_osc_en && exec_en) else $error("run mode");
   rtc_route_a: assert property (timer0_slow_clk |-> sys_clk_fast && exec_en)
      else $error("timer0 route");
endmodule
bind omc_top omc_chk chk (.*);

// ==== dv/omc_top_tb.sv ====
module omc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic startup_fast = 1'b1;
   logic inst_div4_cfg = 1'b1;
   logic wdt_option = 1'b1;
   logic t0_src_cfg = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_exec = 1'b0;
   logic global_int_enable = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] fire = 8'h00;
   logic [7:0] reg_rdata;
   logic [10:0] vector_addr;
   logic fast_osc_en, slow_osc_en, sys_clk_fast, exec_en, periph_en, timer0_run, timer1_run;
   logic watchdog_run, watchdog_clear, timer0_slow_clk, vector_req, inst_div4;
   logic power_down_flag, timeout_flag;
   omc_pkg::omc_wake_t wake_in;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   omc_top dut (.*);
   omc_wake_src src (.clock(clock), .fire(fire), .wake_in(wake_in));
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(logic [10:0] got, logic [10:0] exp, string m);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t %s", $time, m);
         n_fail++;
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e, string m);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(11'(reg_rdata), 11'(e), m);
   endtask
   // wake by one source, then time the resume and read back the mode
   task automatic wk(int b, logic halt, logic vec, logic [7:0] osc);
      int n;
      @(posedge clock);
      fire <= 8'h01 << b;
      @(posedge clock);
      fire <= 8'h00;
      #1;
      for (n = 0; n < 60 && exec_en !== 1'b1; n++)
         @(posedge clock) #1;
      chk(11'(n > 15), 11'(halt), "wake time");
      chk(11'(vector_req), 11'(vec), "vector");
      rd(omc_pkg::OFS_OSC_CTRL, osc, "mode after wake");
      repeat (4) @(posedge clock);
   endtask
   task automatic t_clocks();
      wr(omc_pkg::OFS_OSC_CTRL, 8'h00);
      chk(11'({sys_clk_fast, fast_osc_en}), 11'h1, "slow mode");
      wr(omc_pkg::OFS_OSC_CTRL, 8'h02);
      chk(11'({fast_osc_en, exec_en}), 11'h1, "fast stop");
      wr(omc_pkg::OFS_OSC_CTRL, 8'h01);
      chk(11'({fast_osc_en, slow_osc_en}), 11'h3, "normal");
      chk(11'({periph_en, sys_clk_fast}), 11'h3, "normal clock");
      wr(omc_pkg::OFS_CTRL, 8'h08);
      @(posedge clock) #1;
      chk(11'(timer0_slow_clk), 11'h1, "timer0 slow clock");
      $display("clock test done");
   endtask
   task automatic t_standby();
      wr(omc_pkg::OFS_CTRL, 8'h06);
      for (int b = 0; b < 8; b++)
      begin
         global_int_enable <= 1'(b);
         wr(omc_pkg::OFS_OSC_CTRL, 8'h09);
         chk(11'({exec_en, timer1_run, fast_osc_en}), 11'h3, "standby");
         chk(11'({periph_en, timer0_run}), 11'h1, "standby peripherals");
         wk(b, 1'b0, 1'(b), 8'h01);
      end
      $display("standby test done");
   endtask
   task automatic t_halt();
      int hs[5] = '{5, 4, 3, 1, 0};
      global_int_enable <= 1'b1;
      wr(omc_pkg::OFS_CTRL, 8'h07);
      wr(omc_pkg::OFS_OSC_CTRL, 8'h06);
      chk(11'({power_down_flag, timeout_flag, watchdog_clear}), 11'h3, "halt flags");
      chk(11'({timer0_run, fast_osc_en, slow_osc_en, watchdog_run}), 11'h1, "halt");
      fire <= 8'hC4;
      repeat (12) @(posedge clock);
      #1;
      chk(11'(exec_en), 11'h0, "false wake");
      wk(hs[0], 1'b1, 1'b1, 8'h02);
      for (int i = 1; i < 5; i++)
      begin
         global_int_enable <= 1'b0;
         @(posedge clock);
         sleep_exec <= 1'b1;
         @(posedge clock);
         sleep_exec <= 1'b0;
         #1;
         chk(11'({power_down_flag, exec_en}), 11'h0, "sleep");
         wk(hs[i], 1'b1, 1'b0, 8'h02);
      end
      $display("halt test done");
   endtask
   // free-running clock and hang guard
   initial forever #4 clock = ~clock;
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         n_fail++;
         results();
      end
   end
   initial
   begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(11'(sys_clk_fast), 11'h1, "startup clock");
      chk(vector_addr, omc_pkg::INT_VECTOR, "vector address");
      chk(11'(inst_div4), 11'h1, "instruction divide");
      rd(omc_pkg::OFS_STATUS, 8'h18, "status reset");
      rd(4'hF, 8'h00, "unmapped read");
      t_clocks();
      t_standby();
      t_halt();
      // mid-run reset with the slow startup strap
      startup_fast <= 1'b0;
      inst_div4_cfg <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(11'({sys_clk_fast, inst_div4}), 11'h0, "slow startup");
      rd(omc_pkg::OFS_STATUS, 8'h18, "status after reset");
      $display("reset test done");
      results();
   end
endmodule
